// ===== cfavg_pkg.sv
// cfavg_pkg: register map, field layout, reset values for the coarse frequency averager
package cfavg_pkg;

  // --------------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------------
  localparam logic [11:0] CFAVG_ADDR_EST_LO = 12'h740;
  localparam logic [11:0] CFAVG_ADDR_EST_HI = 12'h741;
  localparam logic [11:0] CFAVG_ADDR_EST_EXP = 12'h745;
  localparam logic [11:0] CFAVG_ADDR_OUT_LO = 12'h750;
  localparam logic [11:0] CFAVG_ADDR_OUT_HI = 12'h751;
  localparam logic [11:0] CFAVG_ADDR_OUT_CONF = 12'h755;
  localparam logic [11:0] CFAVG_ADDR_CTRL = 12'h780;

  // --------------------------------------------------------------------------
  // control byte fields and reset value
  // --------------------------------------------------------------------------
  localparam int CFAVG_CTRL_AVG_EN_BIT = 7;
  localparam int CFAVG_CTRL_INIT_TH_BIT = 6;
  localparam int CFAVG_CTRL_LEN_MSB = 5;
  localparam int CFAVG_CTRL_LEN_LSB = 3;
  localparam int CFAVG_CTRL_DLY_MSB = 2;
  localparam int CFAVG_CTRL_DLY_LSB = 0;
  localparam logic [7:0] CFAVG_CTRL_RESET = 8'hb0;

  // value registers come out of reset at zero
  localparam logic [15:0] CFAVG_EST_RESET = 16'h0000;
  localparam logic [7:0] CFAVG_CONF_RESET = 8'h00;

endpackage : cfavg_pkg

// ===== cfavg_accum.sv
// cfavg_accum: power-of-two sliding average over accepted estimates
`timescale 1ns/1ps
`default_nettype none
module cfavg_accum
  import cfavg_pkg::*;
#(
  parameter int EST_W = 16,
  parameter int DEPTH = 128
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample in
  input wire logic push,
  input wire logic clear,
  input wire logic [EST_W-1:0] sample,
  input wire logic [2:0] len_log2,
  // averaged result once span entries are held, newest sample before that; valid one cycle after push
  output logic [EST_W-1:0] mean,
  output logic [7:0] fill
);

  localparam int IW = $clog2(DEPTH);
  localparam int SW = EST_W + IW;

  logic signed [EST_W-1:0] win_q [DEPTH];
  logic [IW-1:0] wr_q;
  logic [7:0] fill_q;
  logic signed [SW-1:0] sum_c;
  logic [7:0] span;

  // window span is 2**len, clipped to the storage depth
  assign span = (8'h01 << len_log2) > 8'(DEPTH) ? 8'(DEPTH) : (8'h01 << len_log2);

  // --------------------------------------------------------------------------
  // window storage
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      wr_q <= '0;
      fill_q <= 8'h00;
    end
    else if (push)
    begin
      win_q[wr_q] <= sample;
      wr_q <= wr_q + 1'b1;
      if (fill_q < span)
        fill_q <= fill_q + 8'h01;
    end
  end

  // sum the newest span entries; the divide is a shift so span stays a power of two
  always_comb
  begin
    sum_c = '0;
    for (int i = 0; i < DEPTH; i++)
      if (8'(i) < fill_q && 8'(i) < span)
        sum_c = sum_c + SW'(win_q[IW'(wr_q - IW'(i + 1))]);
  end

  always_comb
  begin
    if (fill_q >= span)
      mean = EST_W'(sum_c >>> len_log2);
    else
      mean = (fill_q == 8'h00) ? '0 : win_q[IW'(wr_q - 1'b1)];
  end

  assign fill = fill_q;

endmodule : cfavg_accum
`default_nettype wire

// ===== cfavg_top.sv
// cfavg_top: coarse frequency averager with its byte register map
//
// Contract
// (RULE_01) Each sync sequence yields estimate plus confidence
// (RULE_02) Average only good estimates, drop bad
// (RULE_03) New output only above threshold, else hold; code: at or above, or any estimate in initial phase if init threshold off
// (RULE_04) Output estimate drives control, readable 16-bit
// (RULE_05) Output confidence drives control, readable 8-bit
// (RULE_06) Averaged estimate readable, high byte upper
// (RULE_07) Averaged confidence exponent readable, 8-bit
// (RULE_08) Control byte: enables, length, delay, reset b0
// (RULE_09) Good means confidence at or above threshold
// (RULE_10) Averaging off passes good estimates straight
`timescale 1ns/1ps
`default_nettype none
module cfavg_top
  import cfavg_pkg::*;
#(
  parameter int EST_W = 16,
  parameter int DEPTH = 128
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // per sync_sequence estimate from the coarse_frequency estimator
  input wire logic sync_sequence_valid,
  input wire logic [EST_W-1:0] sync_sequence_est,
  input wire logic [7:0] sync_sequence_conf,
  input wire logic [7:0] conf_threshold,
  // towards the multicarrier frequency control
  output logic multicarrier_valid,
  output logic [EST_W-1:0] multicarrier_est,
  output logic [7:0] multicarrier_conf,
  // byte register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid
);

  typedef enum logic [2:0]
  {
    CFAVG_IDLE = 3'b001,
    CFAVG_AVG = 3'b010,
    CFAVG_EMIT = 3'b100
  } cfavg_state_t;

  cfavg_state_t state_q;
  logic [7:0] ctrl_q;
  logic [15:0] avg_est_q;
  logic [7:0] avg_exp_q;
  logic [15:0] out_est_q;
  logic [7:0] out_conf_q;
  logic [7:0] held_conf_q;
  logic [2:0] init_cnt_q;
  logic good;
  logic in_init;
  logic accept;
  logic [EST_W-1:0] mean;

  // --------------------------------------------------------------------------
  // good/bad decision
  // --------------------------------------------------------------------------
  // during the initial phase with the initial threshold off every estimate counts as good
  assign in_init = ctrl_q[CFAVG_CTRL_AVG_EN_BIT]
                   && (init_cnt_q != ctrl_q[CFAVG_CTRL_DLY_MSB:CFAVG_CTRL_DLY_LSB]);
  assign good = (sync_sequence_conf >= conf_threshold) // RULE_09
                || (in_init && !ctrl_q[CFAVG_CTRL_INIT_TH_BIT]); // RULE_08
  assign accept = sync_sequence_valid && good; // RULE_01 RULE_02 RULE_03

  cfavg_accum #(
    .EST_W(EST_W),
    .DEPTH(DEPTH)
  ) u_accum (
    .clk(clk),
    .rst_n(rst_n),
    .push(accept && ctrl_q[CFAVG_CTRL_AVG_EN_BIT]), // RULE_02
    .clear(!ctrl_q[CFAVG_CTRL_AVG_EN_BIT]),
    .sample(sync_sequence_est),
    .len_log2(ctrl_q[CFAVG_CTRL_LEN_MSB:CFAVG_CTRL_LEN_LSB]), // RULE_08
    .mean(mean),
    .fill()
  );

  // --------------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= CFAVG_IDLE;
    else
    begin
      case (state_q)
        CFAVG_IDLE:
          if (accept)
            state_q <= ctrl_q[CFAVG_CTRL_AVG_EN_BIT] ? CFAVG_AVG : CFAVG_EMIT;
        CFAVG_AVG:
          state_q <= CFAVG_EMIT;
        CFAVG_EMIT:
          state_q <= CFAVG_IDLE;
        default:
          state_q <= CFAVG_IDLE;
      endcase
    end
  end

  // initial-delay counter restarts whenever averaging is switched off
  always_ff @(posedge clk)
  begin
    if (!rst_n || !ctrl_q[CFAVG_CTRL_AVG_EN_BIT])
      init_cnt_q <= 3'h0;
    else if (accept && in_init)
      init_cnt_q <= init_cnt_q + 3'h1;
  end

  // --------------------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      avg_est_q <= CFAVG_EST_RESET;
      avg_exp_q <= CFAVG_CONF_RESET;
      held_conf_q <= CFAVG_CONF_RESET;
    end
    else if (state_q == CFAVG_IDLE && accept)
    begin
      held_conf_q <= sync_sequence_conf;
      if (!ctrl_q[CFAVG_CTRL_AVG_EN_BIT])
      begin
        avg_est_q <= 16'(sync_sequence_est); // RULE_10
        avg_exp_q <= sync_sequence_conf; // RULE_10
      end
    end
    else if (state_q == CFAVG_AVG)
    begin
      avg_est_q <= 16'(mean); // RULE_06
      avg_exp_q <= held_conf_q; // RULE_07
    end
    else if (reg_wr && reg_addr == CFAVG_ADDR_EST_LO)
      avg_est_q[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == CFAVG_ADDR_EST_HI)
      avg_est_q[15:8] <= reg_wdata;
  end

  // output register moves on an accepted estimate or a write to CFAVG_ADDR_OUT_LO/HI, otherwise it holds
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_est_q <= CFAVG_EST_RESET;
      out_conf_q <= CFAVG_CONF_RESET;
    end
    else if (state_q == CFAVG_EMIT)
    begin
      out_est_q <= avg_est_q; // RULE_03 RULE_04
      out_conf_q <= avg_exp_q; // RULE_05
    end
    else if (reg_wr && reg_addr == CFAVG_ADDR_OUT_LO)
      out_est_q[7:0] <= reg_wdata;
    else if (reg_wr && reg_addr == CFAVG_ADDR_OUT_HI)
      out_est_q[15:8] <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      multicarrier_valid <= 1'b0;
    else
      multicarrier_valid <= (state_q == CFAVG_EMIT);
  end

  assign multicarrier_est = EST_W'(out_est_q); // RULE_04
  assign multicarrier_conf = out_conf_q; // RULE_05

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_q <= CFAVG_CTRL_RESET; // RULE_08
    else if (reg_wr && reg_addr == CFAVG_ADDR_CTRL)
      ctrl_q <= reg_wdata; // RULE_08
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        CFAVG_ADDR_EST_LO: reg_rdata <= avg_est_q[7:0]; // RULE_06
        CFAVG_ADDR_EST_HI: reg_rdata <= avg_est_q[15:8]; // RULE_06
        CFAVG_ADDR_EST_EXP: reg_rdata <= avg_exp_q; // RULE_07
        CFAVG_ADDR_OUT_LO: reg_rdata <= out_est_q[7:0]; // RULE_04
        CFAVG_ADDR_OUT_HI: reg_rdata <= out_est_q[15:8]; // RULE_04
        CFAVG_ADDR_OUT_CONF: reg_rdata <= out_conf_q; // RULE_05
        CFAVG_ADDR_CTRL: reg_rdata <= ctrl_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_ctrl_reset: assert property (@(posedge clk) // RULE_08
    !rst_n |=> ctrl_q == CFAVG_CTRL_RESET)
    else $error("control byte not at reset value");
  a_bad_holds: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (state_q == CFAVG_IDLE && sync_sequence_valid && !good && !reg_wr)
    |=> $stable(out_est_q))
    else $error("output moved on a bad estimate");
  a_good_emits: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (state_q == CFAVG_IDLE && accept) |-> ##[2:3] multicarrier_valid)
    else $error("good estimate not delivered");
  a_thresh_good: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (sync_sequence_conf >= conf_threshold) |-> good)
    else $error("estimate at threshold judged bad");
  a_pass_thru: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (state_q == CFAVG_IDLE && accept && !ctrl_q[CFAVG_CTRL_AVG_EN_BIT] && !reg_wr)
    |=> ##1 out_est_q == 16'($past(sync_sequence_est, 2)))
    else $error("pass-through estimate wrong");
  a_conf_out: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    multicarrier_valid |-> multicarrier_conf == avg_exp_q)
    else $error("confidence not aligned with estimate");
  a_read_hi: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    (reg_rd && reg_addr == CFAVG_ADDR_EST_HI) |=> reg_rdata == $past(avg_est_q[15:8]))
    else $error("averaged high byte misread");
  a_read_exp: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (reg_rd && reg_addr == CFAVG_ADDR_EST_EXP) |=> reg_rdata == $past(avg_exp_q))
    else $error("exponent misread");
  a_out_drive: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    multicarrier_est == EST_W'(out_est_q))
    else $error("frequency control not fed by output register");
  a_fresh_conf: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (state_q == CFAVG_IDLE && accept && ctrl_q[CFAVG_CTRL_AVG_EN_BIT])
    |=> held_conf_q == $past(sync_sequence_conf))
    else $error("confidence not captured");

  c_pass: cover property (@(posedge clk) disable iff (!rst_n)
    accept && !ctrl_q[CFAVG_CTRL_AVG_EN_BIT]);
  c_avg: cover property (@(posedge clk) disable iff (!rst_n) state_q == CFAVG_AVG);
  c_bad: cover property (@(posedge clk) disable iff (!rst_n) sync_sequence_valid && !good);
  c_ctrl_wr: cover property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == CFAVG_ADDR_CTRL);

endmodule : cfavg_top
`default_nettype wire

// ===== cfavg_fc_model.sv
// cfavg_fc_model: frequency control side, captures each averager delivery
`timescale 1ns/1ps
`default_nettype none
module cfavg_fc_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // delivery from the averager
  input wire logic valid,
  input wire logic [15:0] est,
  input wire logic [7:0] conf,
  // captured values
  output logic [7:0] n_q,
  output logic [15:0] est_q,
  output logic [7:0] conf_q
);
  // est and conf are taken as one unit, only on the valid cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      n_q <= 8'h00;
    end
    else if (valid)
    begin
      n_q <= n_q + 8'h01;
      est_q <= est;
      conf_q <= conf;
    end
  end
endmodule : cfavg_fc_model
`default_nettype wire

// ===== cfavg_top_tb.sv
// cfavg_top_tb: register map and estimate path tests for the averager
`timescale 1ns/1ps
`default_nettype none
module cfavg_top_tb;
  import cfavg_pkg::*;
  logic clk, rst_n, sv, rw, rr, mv, rvalid;
  logic [15:0] se, me, fe, w;
  logic [7:0] sc, th, mc, wd, rd, fn, fc, b;
  logic [11:0] ra;
  int n_mismatch = 0;
  int total_checks = 0;
  cfavg_top dut (.clk(clk), .rst_n(rst_n), .sync_sequence_valid(sv),
    .sync_sequence_est(se), .sync_sequence_conf(sc), .conf_threshold(th),
    .multicarrier_valid(mv), .multicarrier_est(me), .multicarrier_conf(mc),
    .reg_wr(rw), .reg_rd(rr), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rd),
    .reg_rvalid(rvalid));
  cfavg_fc_model fcm (.clk(clk), .rst_n(rst_n), .valid(mv), .est(me), .conf(mc),
    .n_q(fn), .est_q(fe), .conf_q(fc));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // --------------------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    rw = 1'b1; ra = a; wd = d;
    @(negedge clk);
    rw = 1'b0;
  endtask : wr
  // read data is registered, so it stands at the negedge after the request
  task automatic rdb(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    rr = 1'b1; ra = a;
    @(negedge clk);
    rr = 1'b0;
    d = rd;
    check("read valid", {15'h0000, rvalid}, 16'h0001);
  endtask : rdb
  // no latching of the pair, so both bytes are read while the path is idle
  task automatic rd16(input logic [11:0] a, output logic [15:0] v);
    logic [7:0] lo, hi;
    rdb(a, lo);
    rdb(a + 12'h001, hi);
    v = {hi, lo};
  endtask : rd16
  task automatic send(input logic [15:0] e, input logic [7:0] c, input logic good);
    logic [7:0] n0;
    int i;
    n0 = fn;
    @(negedge clk);
    sv = 1'b1; se = e; sc = c;
    @(negedge clk);
    sv = 1'b0;
    for (i = 0; i < 8 && fn === n0; i++) @(negedge clk);
    check("delivery count", {8'h00, 8'(fn - n0)}, {15'h0000, good});
    if (good && fn === n0)
      test_done();
  endtask : send
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    int k;
    rst_n = 1'b0; sv = 1'b0; rw = 1'b0; rr = 1'b0; se = 16'h0000;
    sc = 8'h00; th = 8'h40; ra = 12'h000; wd = 8'h00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rdb(CFAVG_ADDR_CTRL, b); check("ctrl reset", b, 16'h00b0);
    rd16(CFAVG_ADDR_OUT_LO, w); check("out reset", w, 16'h0000);
    wr(12'h7ff, 8'h5a); rdb(12'h7ff, b); check("unmapped", b, 16'h0000);
    wr(CFAVG_ADDR_OUT_CONF, 8'hff); rdb(CFAVG_ADDR_OUT_CONF, b);
    check("out conf ro", b, 16'h0000);
    wr(CFAVG_ADDR_EST_EXP, 8'hff); rdb(CFAVG_ADDR_EST_EXP, b);
    check("est exp ro", b, 16'h0000);
    wr(CFAVG_ADDR_CTRL, 8'h00); rdb(CFAVG_ADDR_CTRL, b); check("ctrl", b, 16'h0000);
    $display("test registers done");
    send(16'h1234, 8'h40, 1'b1);
    check("fc est", fe, 16'h1234);
    check("fc conf", fc, 16'h0040);
    rd16(CFAVG_ADDR_OUT_LO, w); check("out est", w, 16'h1234);
    rdb(CFAVG_ADDR_OUT_CONF, b); check("out conf", b, 16'h0040);
    rdb(CFAVG_ADDR_EST_EXP, b); check("est exp", b, 16'h0040);
    send(16'h7777, 8'h3f, 1'b0);
    check("held est", me, 16'h1234);
    send(16'h8001, 8'hc5, 1'b1);
    rd16(CFAVG_ADDR_EST_LO, w); check("avg est", w, 16'h8001);
    $display("test pass through done");
    do_reset();
    wr(CFAVG_ADDR_CTRL, 8'h88);
    send(16'h0100, 8'h50, 1'b1); check("fc est", fe, 16'h0100);
    send(16'h0500, 8'h20, 1'b0);
    send(16'h0300, 8'h60, 1'b1); check("fc est", fe, 16'h0200);
    check("fc conf", fc, 16'h0060);
    send(16'h0500, 8'h41, 1'b1); check("fc est", fe, 16'h0400);
    rd16(CFAVG_ADDR_EST_LO, w); check("avg est", w, 16'h0400);
    $display("test averaging done");
    for (k = 0; k < 2; k++)
    begin
      do_reset();
      // the initial phase only exists while averaging is on, so bit 7 stays set
      wr(CFAVG_ADDR_CTRL, (k == 1) ? 8'hc1 : 8'h81);
      send(16'h0aaa, 8'h10, k == 0);
      send(16'h0bbb, 8'h10, 1'b0);
    end
    $display("test initial threshold done");
    test_done();
  end
endmodule : cfavg_top_tb
`default_nettype wire
